// ### dv/srp_fabric_model.sv
module srp_fabric_model
(
  input wire logic clk,
  input wire logic nrst,
  output logic dec_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // Random stalls so that held decisions get exercised
  always @(posedge clk)
    dec_ready <= nrst && ($urandom_range(0, 3) != 0);
endmodule : srp_fabric_model

// ### dv/srp_policy_asserts.sv
module srp_policy_asserts
  import srp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hot_reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tlp_valid,
  input wire srp_pkg::srp_tlp_s tlp_in,
  input wire logic tlp_ready,
  input wire logic dec_valid,
  input wire srp_pkg::srp_dec_s dec_out,
  input wire logic dec_ready,
  input wire logic hr_eeprom_step,
  input wire logic eeprom_load_start,
  input wire logic eeprom_step_skipped,
  input wire logic hot_reset_eeprom_skip,
  input wire logic relaxed_order_disable,
  input wire logic cut_through_disable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // Bus answers in exactly one wait state, then idles again
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_rsvd_zero: assert property (!avs_waitrequest && avs_read |-> (avs_readdata & ~CTL_WMASK) == '0)
    else $error("reserved bits read nonzero");
  // Step pulse picks load or skip from the bit as it stood
  chk_eep_choice: assert property (hr_eeprom_step |=> eeprom_step_skipped == $past(hot_reset_eeprom_skip)
    && eeprom_load_start != $past(hot_reset_eeprom_skip)) else $error("eeprom step choice wrong");
  chk_eep_quiet: assert property (!hr_eeprom_step |=> !eeprom_load_start && !eeprom_step_skipped)
    else $error("eeprom pulse without step");
  ////////////////////////////////////////////////////////////////
  // Decision follows acceptance by one cycle and carries the tag
  chk_dec_tag: assert property (tlp_valid && tlp_ready |=> dec_valid && !tlp_ready && dec_out.tag == $past(tlp_in.tag))
    else $error("decision missing or tag wrong");
  chk_strong_ord: assert property (tlp_valid && tlp_ready |=>
    dec_out.strong_order == ($past(relaxed_order_disable) || !$past(tlp_in.ro_attr))) else $error("ordering wrong");
  chk_store_fwd: assert property (tlp_valid && tlp_ready |=> dec_out.store_fwd == $past(cut_through_disable))
    else $error("routing style wrong");
  chk_dec_hold: assert property (dec_valid && !dec_ready && !hot_reset |=> dec_valid && $stable(dec_out))
    else $error("decision not held");
  chk_drop_clean: assert property (dec_valid && dec_out.action == SRP_SILENT_DROP |->
    dec_out.credit_return && !dec_out.err_set) else $error("discard not silent");
  // Hot reset flushes the slot and refuses new TLPs, register untouched
  chk_hot_flush: assert property (hot_reset |=> !tlp_ready && !dec_valid)
    else $error("hot reset did not flush stream");
  cov_write: cover property (avs_write && !avs_waitrequest);
  cov_drop: cover property (dec_valid && dec_ready && dec_out.action == SRP_SILENT_DROP);
  cov_skip: cover property (eeprom_step_skipped);
endmodule : srp_policy_asserts

bind srp_policy srp_policy_asserts srp_policy_asserts_i (.clk, .nrst, .hot_reset, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .tlp_valid, .tlp_in, .tlp_ready, .dec_valid, .dec_out, .dec_ready,
  .hr_eeprom_step, .eeprom_load_start, .eeprom_step_skipped, .hot_reset_eeprom_skip,
  .relaxed_order_disable, .cut_through_disable);

// ### dv/srp_policy_tb_top.sv
module srp_policy_tb_top;
  import srp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, nrst = 1'b0, hot_reset = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic tlp_valid = 1'b0, tlp_ready, dec_valid, dec_ready, hr_eeprom_step = 1'b0, eeprom_load_start;
  logic eeprom_step_skipped, hot_reset_eeprom_skip, relaxed_order_disable, cut_through_disable;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, ctl_m = '0;
  logic [3:0] avs_byteenable = '0;
  srp_tlp_s tlp_in = '0;
  srp_dec_s dec_out, de;
  srp_dec_s dq[$];
  logic [31:0] rq[$];
  logic [1:0] eq[$];
  int err_count = 0, checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  srp_policy srp_policy_i (.clk, .nrst, .hot_reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tlp_valid, .tlp_in, .tlp_ready, .dec_valid, .dec_out,
    .dec_ready, .hr_eeprom_step, .eeprom_load_start, .eeprom_step_skipped, .hot_reset_eeprom_skip,
    .relaxed_order_disable, .cut_through_disable);
  srp_fabric_model srp_fabric_model_i (.clk, .nrst, .dec_ready);
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g)
    begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask : cmp
  task conclude;
    if (dq.size() + rq.size() + eq.size() != 0)
      err_count++;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Master holds the request until waitrequest is seen low
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    for (int i = 0; i < 4; i++)
      if (be[i] && a == CTL_ADDR)
        ctl_m[8*i +: 8] = d[8*i +: 8] & CTL_WMASK[8*i +: 8];
    avs_write <= 1'b0;
    @(posedge clk);
    // Level outputs follow the register from the write edge on
    cmp("levels", {29'h0, ctl_m[EEP_SKIP_BIT], ctl_m[RO_DIS_BIT], ctl_m[CT_DIS_BIT]},
      {29'h0, hot_reset_eeprom_skip, relaxed_order_disable, cut_through_disable});
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a);
    rq.push_back(a == CTL_ADDR ? ctl_m : RD_UNMAPPED);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus_rd
  // Reference decision, reckoned only from the control word and the offered TLP
  function automatic srp_dec_s exp_dec(input logic [31:0] c, input srp_tlp_s t);
    srp_dec_s d;
    logic dn, up, blk;
    d = '0;
    dn = !t.ingress_up;
    up = c[UP_CHK_BIT] && dn && t.id_routed && t.tgt_class == TGT_UP_BUS && t.dev_num != DEV_ZERO;
    blk = t.id_routed && t.tgt_class == TGT_DN_BUS && t.dev_num != DEV_ZERO && !t.egress_ari_en
      && (c[10:9] == DN_CHK_ALL || (c[10:9] == DN_CHK_CFG && t.is_cfg));
    if ((t.ingress_up && t.vend_bcast_t1 && c[BCAST_DROP_BIT]) || ((up || blk) && t.is_cpl))
      {d.action, d.credit_return} = {SRP_SILENT_DROP, 1'b1};
    else if ((c[P2P_DIS_BIT] && dn && !t.dest_up) || up || blk)
      {d.action, d.err_set} = {SRP_UNSUP_REQ, 1'b1};
    d.strong_order = c[RO_DIS_BIT] || !t.ro_attr;
    d.store_fwd = c[CT_DIS_BIT];
    d.lock_effect = t.locked && !c[LOCK_IGN_BIT];
    d.tag = t.tag;
    return d;
  endfunction : exp_dec
  task automatic send_tlp(input srp_tlp_s t);
    tlp_valid <= 1'b1;
    tlp_in <= t;
    do @(posedge clk); while (tlp_ready !== 1'b1);
    dq.push_back(exp_dec(ctl_m, t));
    tlp_valid <= 1'b0;
    @(posedge clk);
  endtask : send_tlp
  ////////////////////////////////////////////////////////////////
  // Watcher takes the oldest note whenever a result appears
  always @(posedge clk)
  begin
    if (nrst && !avs_waitrequest && avs_read)
      cmp("readdata", rq.pop_front(), avs_readdata);
    if (nrst && (eeprom_load_start || eeprom_step_skipped))
      cmp("eeprom", {30'h0, eq.pop_front()}, {30'h0, eeprom_load_start, eeprom_step_skipped});
    if (nrst && dec_valid && dec_ready)
    begin
      de = dq.pop_front();
      cmp("dec_out", {17'h0, de}, {17'h0, dec_out});
    end
    // Timeout last, so nothing in this process follows the finish
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(85444));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus_rd(CTL_ADDR);
    bus_wr(CTL_ADDR, 32'hFFFF_FFFF, 4'hF);
    bus_rd(CTL_ADDR);
    bus_wr(CTL_ADDR, 32'h0000_0000, 4'h2);
    bus_wr(4'h5, 32'hFFFF_FFFF, 4'hF);
    bus_rd(4'h5);
    bus_rd(CTL_ADDR);
    $display("test registers done");
    for (int i = 0; i < 2; i++)
    begin
      bus_wr(CTL_ADDR, i << EEP_SKIP_BIT, 4'hF);
      eq.push_back({i == 0, i == 1});
      hr_eeprom_step <= 1'b1;
      @(posedge clk);
      hr_eeprom_step <= 1'b0;
      repeat (3) @(posedge clk);
    end
    $display("test eeprom step done");
    // Sticky word survives a hot reset but not a fundamental one
    bus_wr(CTL_ADDR, 32'h0008_CAC0, 4'hF);
    hot_reset <= 1'b1;
    repeat (3) @(posedge clk);
    hot_reset <= 1'b0;
    repeat (2) @(posedge clk);
    bus_rd(CTL_ADDR);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    ctl_m = CTL_RESET;
    @(posedge clk);
    bus_rd(CTL_ADDR);
    $display("test resets done");
    for (int n = 0; n < 300; n++)
    begin
      if (n % 20 == 0)
        bus_wr(CTL_ADDR, $urandom, 4'hF);
      send_tlp(srp_tlp_s'($urandom));
    end
    repeat (20) @(posedge clk);
    $display("test forwarding done");
    conclude();
  end
endmodule : srp_policy_tb_top

// ### hdl/srp_devnum_chk.sv
module srp_devnum_chk
  import srp_pkg::*;
(
  input wire logic [srp_pkg::DN_MODE_W-1:0] mode,
  input wire logic ari_en,
  input wire logic id_routed,
  input wire logic is_cfg,
  input wire logic to_dn_bus,
  input wire logic dev_nonzero,
  output logic block
);

  ////////////////////////////////////////////////////////////////////////////
  // Candidate for blocking: ID routed, downstream link bus, nonzero device
  wire logic candidate;
  wire logic mode_all;
  wire logic mode_cfg;

  assign candidate = id_routed & to_dn_bus & dev_nonzero;
  assign mode_all = (mode == DN_CHK_ALL);
  assign mode_cfg = (mode == DN_CHK_CFG) & is_cfg;
  // Mode none and the unused code 3 both pass everything
  // An ARI-forwarding port ignores the check entirely
  assign block = candidate & ~ari_en & (mode_all | mode_cfg);

endmodule : srp_devnum_chk

// ### hdl/srp_policy.sv
module srp_policy
  import srp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hot_reset,
  input wire logic [srp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tlp_valid,
  input wire srp_pkg::srp_tlp_s tlp_in,
  output logic tlp_ready,
  output logic dec_valid,
  output srp_pkg::srp_dec_s dec_out,
  input wire logic dec_ready,
  input wire logic hr_eeprom_step,
  output logic eeprom_load_start,
  output logic eeprom_step_skipped,
  output logic hot_reset_eeprom_skip,
  output logic relaxed_order_disable,
  output logic cut_through_disable
);

  ////////////////////////////////////////////////////////////////////////////
  // Register and pipeline state
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic dec_valid_r;
  logic dec_valid_nxt;
  srp_dec_s dec_r;
  srp_dec_s dec_nxt;
  logic tlp_ready_r;
  logic load_start_r;
  logic step_skip_r;
  logic eep_skip_r;
  logic ro_dis_r;
  logic ct_dis_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control field views
  wire logic f_eep_skip;
  wire logic f_ro_dis;
  wire logic f_p2p_dis;
  wire logic [DN_MODE_W-1:0] f_dn_mode;
  wire logic f_up_chk;
  wire logic f_ct_dis;
  wire logic f_lock_ign;
  wire logic f_bcast_drop;

  assign f_eep_skip = ctl_r[EEP_SKIP_BIT];
  assign f_ro_dis = ctl_r[RO_DIS_BIT];
  assign f_p2p_dis = ctl_r[P2P_DIS_BIT];
  assign f_dn_mode = ctl_r[DN_MODE_LSB +: DN_MODE_W];
  assign f_up_chk = ctl_r[UP_CHK_BIT];
  assign f_ct_dis = ctl_r[CT_DIS_BIT];
  assign f_lock_ign = ctl_r[LOCK_IGN_BIT];
  assign f_bcast_drop = ctl_r[BCAST_DROP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave decode
  // One wait state: the request is seen with waitrequest high, answered
  // with waitrequest low on the next cycle, so readdata can be a flop.
  wire logic req;
  wire logic take;
  wire logic hit_ctl;
  wire logic wr_ctl;
  wire logic rd_ctl;

  assign req = avs_read | avs_write;
  assign take = req & ~wait_r;
  assign hit_ctl = (avs_address == CTL_ADDR);
  assign wr_ctl = take & avs_write & hit_ctl;
  assign rd_ctl = avs_read & hit_ctl;

  // Per byte lane write merge, masked so unused bits never store
  wire logic [31:0] lane_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  wire logic [31:0] wr_mask;
  assign wr_mask = lane_mask & CTL_WMASK;

  // Next control value; hot_reset is deliberately absent here
  always_comb
  begin
    ctl_nxt = ctl_r;
    if (wr_ctl)
    begin
      ctl_nxt = (ctl_r & ~wr_mask) | (avs_writedata & wr_mask);
    end
  end

  // Read data: reserved and omitted bits are held at zero in the flop
  always_comb
  begin
    rdata_nxt = RD_UNMAPPED;
    if (rd_ctl)
    begin
      rdata_nxt = ctl_r & CTL_WMASK;
    end
  end

  // Sticky control: only the fundamental reset clears it
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ctl_r <= CTL_RESET;
    else
      ctl_r <= ctl_nxt;
  end

  // Bus handshake flops
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wait_r <= 1'b1;
      rdata_r <= RD_UNMAPPED;
    end
    else
    begin
      wait_r <= ~(req & wait_r);
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classification of the offered TLP
  wire logic from_dn;
  wire logic dev_nonzero;
  wire logic to_up_bus;
  wire logic to_dn_bus;
  wire logic is_req;

  assign from_dn = ~tlp_in.ingress_up;
  assign dev_nonzero = (tlp_in.dev_num != DEV_ZERO);
  assign to_up_bus = (tlp_in.tgt_class == TGT_UP_BUS);
  assign to_dn_bus = (tlp_in.tgt_class == TGT_DN_BUS);
  assign is_req = ~tlp_in.is_cpl;

  // Downstream device-number check
  wire logic dn_block;

  srp_devnum_chk u_devnum_chk
  (
    .mode(f_dn_mode),
    .ari_en(tlp_in.egress_ari_en),
    .id_routed(tlp_in.id_routed),
    .is_cfg(tlp_in.is_cfg),
    .to_dn_bus(to_dn_bus),
    .dev_nonzero(dev_nonzero),
    .block(dn_block)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Individual policy verdicts
  wire logic bcast_drop;
  wire logic p2p_ur;
  wire logic up_hit;
  wire logic up_ur;
  wire logic up_drop;
  wire logic dn_ur;
  wire logic dn_drop;

  // Vendor Type 1 broadcast from the upstream side
  assign bcast_drop = f_bcast_drop & tlp_in.ingress_up & tlp_in.vend_bcast_t1;
  // Peer traffic between downstream ports is refused
  assign p2p_ur = f_p2p_dis & from_dn & ~tlp_in.dest_up;
  // Nonzero device aimed at the upstream link bus from below
  assign up_hit = f_up_chk & from_dn & tlp_in.id_routed & to_up_bus & dev_nonzero;
  assign up_ur = up_hit & is_req;
  assign up_drop = up_hit & tlp_in.is_cpl;
  // A blocked completion has no requester to answer, so it is discarded
  assign dn_ur = dn_block & is_req;
  assign dn_drop = dn_block & tlp_in.is_cpl;

  wire logic any_drop;
  wire logic any_ur;

  assign any_drop = bcast_drop | up_drop | dn_drop;
  assign any_ur = p2p_ur | up_ur | dn_ur;

  ////////////////////////////////////////////////////////////////////////////
  // Decision assembly
  // Discard wins over UR: a discarded TLP must raise no error at all.
  always_comb
  begin
    dec_nxt = dec_r;
    if (tlp_valid & tlp_ready_r)
    begin
      dec_nxt.tag = tlp_in.tag;
      dec_nxt.strong_order = f_ro_dis | ~tlp_in.ro_attr;
      dec_nxt.store_fwd = f_ct_dis;
      dec_nxt.lock_effect = tlp_in.locked & ~f_lock_ign;
      if (any_drop)
      begin
        dec_nxt.action = SRP_SILENT_DROP;
        dec_nxt.credit_return = 1'b1;
        dec_nxt.err_set = 1'b0;
      end
      else if (any_ur)
      begin
        dec_nxt.action = SRP_UNSUP_REQ;
        dec_nxt.credit_return = 1'b0;
        dec_nxt.err_set = 1'b1;
      end
      else
      begin
        dec_nxt.action = SRP_FORWARD;
        dec_nxt.credit_return = 1'b0;
        dec_nxt.err_set = 1'b0;
      end
    end
  end

  // Output slot bookkeeping; hot reset flushes an unconsumed decision
  wire logic accept;
  wire logic drain;

  assign accept = tlp_valid & tlp_ready_r;
  assign drain = dec_valid_r & dec_ready;

  always_comb
  begin
    dec_valid_nxt = dec_valid_r;
    if (hot_reset)
      dec_valid_nxt = 1'b0;
    else if (accept)
      dec_valid_nxt = 1'b1;
    else if (drain)
      dec_valid_nxt = 1'b0;
  end

  // Registered ready costs a bubble: one decision per two cycles at best
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      dec_valid_r <= 1'b0;
      tlp_ready_r <= 1'b0;
    end
    else
    begin
      dec_valid_r <= dec_valid_nxt;
      tlp_ready_r <= ~dec_valid_nxt & ~hot_reset;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      dec_r.action <= SRP_FORWARD;
      dec_r.credit_return <= 1'b0;
      dec_r.err_set <= 1'b0;
      dec_r.strong_order <= 1'b0;
      dec_r.store_fwd <= 1'b0;
      dec_r.lock_effect <= 1'b0;
      dec_r.tag <= '0;
    end
    else
      dec_r <= dec_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hot reset EEPROM step
  // The sequencer pulses hr_eeprom_step on reaching that step and waits for
  // either a load start or a skip notice, whatever the operating mode.
  wire logic do_load;
  wire logic do_skip;

  assign do_load = hr_eeprom_step & ~f_eep_skip;
  assign do_skip = hr_eeprom_step & f_eep_skip;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      load_start_r <= 1'b0;
      step_skip_r <= 1'b0;
    end
    else
    begin
      load_start_r <= do_load;
      step_skip_r <= do_skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global mode levels for the fabric, registered copies of the fields
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      eep_skip_r <= 1'b0;
      ro_dis_r <= 1'b0;
      ct_dis_r <= 1'b0;
    end
    else
    begin
      eep_skip_r <= ctl_nxt[EEP_SKIP_BIT];
      ro_dis_r <= ctl_nxt[RO_DIS_BIT];
      ct_dis_r <= ctl_nxt[CT_DIS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tlp_ready = tlp_ready_r;
  assign dec_valid = dec_valid_r;
  assign dec_out = dec_r;
  assign eeprom_load_start = load_start_r;
  assign eeprom_step_skipped = step_skip_r;
  assign hot_reset_eeprom_skip = eep_skip_r;
  assign relaxed_order_disable = ro_dis_r;
  assign cut_through_disable = ct_dis_r;

endmodule : srp_policy

// ### inc/srp_pkg.sv
package srp_pkg;

  // Register map, word addresses on the Avalon slave
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTL_ADDR = 4'h0;

  // Control field positions
  localparam int unsigned EEP_SKIP_BIT = 6;
  localparam int unsigned RO_DIS_BIT = 7;
  localparam int unsigned P2P_DIS_BIT = 8;
  localparam int unsigned DN_MODE_LSB = 9;
  localparam int unsigned DN_MODE_W = 2;
  localparam int unsigned UP_CHK_BIT = 11;
  localparam int unsigned CT_DIS_BIT = 14;
  localparam int unsigned LOCK_IGN_BIT = 15;
  localparam int unsigned BCAST_DROP_BIT = 19;

  // Only these bits hold state; reserved and omitted bits read zero
  localparam logic [31:0] CTL_WMASK = 32'h0008_CFC0;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Downstream device-number check modes
  localparam logic [DN_MODE_W-1:0] DN_CHK_ALL = 2'h0;
  localparam logic [DN_MODE_W-1:0] DN_CHK_CFG = 2'h1;
  localparam logic [DN_MODE_W-1:0] DN_CHK_NONE = 2'h2;

  // Target bus classes of an ID-routed TLP
  localparam logic [1:0] TGT_OTHER = 2'h0;
  localparam logic [1:0] TGT_UP_BUS = 2'h1;
  localparam logic [1:0] TGT_DN_BUS = 2'h2;

  localparam int unsigned DEV_W = 5;
  localparam logic [DEV_W-1:0] DEV_ZERO = 5'h00;
  localparam int unsigned TAG_W = 8;

  typedef enum logic [1:0] {
    SRP_FORWARD,
    SRP_UNSUP_REQ,
    SRP_SILENT_DROP
  } srp_act_e;

  // Header summary of one TLP offered for a forwarding decision
  typedef struct packed {
    logic ingress_up;
    logic dest_up;
    logic id_routed;
    logic is_cfg;
    logic is_cpl;
    logic vend_bcast_t1;
    logic locked;
    logic ro_attr;
    logic [1:0] tgt_class;
    logic [DEV_W-1:0] dev_num;
    logic egress_ari_en;
    logic [TAG_W-1:0] tag;
  } srp_tlp_s;

  // Decision handed to the routing fabric
  typedef struct packed {
    srp_act_e action;
    logic credit_return;
    logic err_set;
    logic strong_order;
    logic store_fwd;
    logic lock_effect;
    logic [TAG_W-1:0] tag;
  } srp_dec_s;

endpackage : srp_pkg
